/* File: src/pmrc_pkg.sv */
// package: register map, field layout and timing for the power monitor register block
package pmrc_pkg;

    // register pointers
    localparam logic [2:0] PTR_CONFIG      = 3'h0;
    localparam logic [2:0] PTR_SHUNT       = 3'h1;
    localparam logic [2:0] PTR_BUS         = 3'h2;
    localparam logic [2:0] PTR_POWER       = 3'h3;
    localparam logic [2:0] PTR_CURRENT     = 3'h4;
    localparam logic [2:0] PTR_CALIB       = 3'h5;

    // reset values and configuration write mask
    localparam logic [15:0] CONFIG_RESET   = 16'h399F;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;
    localparam logic [15:0] CALIB_RESET    = 16'h0000;
    localparam logic [15:0] CONFIG_WMASK   = 16'hBFFF;

    // field positions
    localparam int BUS_SHIFT               = 3;
    localparam int BUS_CNT_W               = 13;

    // arithmetic constants
    localparam logic signed [32:0] CURRENT_DIV = 33'sh0_0000_0FFF;
    localparam logic [28:0]        POWER_DIV   = 29'h0000_1388;
    localparam logic [15:0]        SHUNT_BASE  = 16'h0FA0;

    // timing
    localparam int CLK_PERIOD_NS           = 40;
    localparam int WR_SETTLE_NS            = 4000;
    localparam int WR_SETTLE_CYC           = (WR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WR_SETTLE_LD    = 8'(WR_SETTLE_CYC - 1);

    // configuration register layout
    typedef struct packed {
        logic       soft_reset;
        logic       unused_bit;
        logic       bus_range_select;
        logic       shunt_gain_hi;
        logic       shunt_gain_lo;
        logic [3:0] bus_conv_setting;
        logic [3:0] shunt_conv_setting;
        logic [2:0] mode;
    } pmrc_config_t;

    // a write travelling from link to core
    typedef struct packed {
        logic [2:0]  ptr;
        logic [15:0] data;
    } pmrc_write_t;

    typedef enum logic [1:0] {
        WR_IDLE   = 2'b00,
        WR_SETTLE = 2'b01,
        WR_APPLY  = 2'b11
    } pmrc_wr_state_t;

endpackage : pmrc_pkg

/* File: src/pmrc_top.sv */
// module: register bank, result arithmetic and byte link of the power monitor
`timescale 1ns/1ps
`default_nettype none
module pmrc_top
    import pmrc_pkg::*;
(
    // core clock and reset
    input  wire  logic                 i_ref_clk,
    input  wire  logic                 i_reset_n,
    // link side, on the link clock
    input  wire  logic                 i_link_clk,
    input  wire  logic                 i_lk_ptr_we,
    input  wire  logic                 i_lk_wr_stb,
    input  wire  logic                 i_lk_rd_stb,
    input  wire  logic [7:0]           i_lk_byte,
    output var   logic [7:0]           o_lk_rd_byte,
    output var   logic                 o_lk_rd_valid,
    output var   logic                 o_lk_wr_busy,
    // converter results
    input  wire  logic                 i_shunt_valid,
    input  wire  logic [15:0]          i_shunt_raw,
    input  wire  logic                 i_bus_valid,
    input  wire  logic [BUS_CNT_W-1:0] i_bus_raw,
    // converter settings
    output var   pmrc_config_t         o_config
);

    // magnitude of a signed word
    function automatic logic [15:0] abs16(input logic [15:0] v);
        abs16 = v[15] ? 16'(~v + 16'h0001) : v;
    endfunction : abs16

    // ---------------- link domain ----------------
    logic [2:0]  lk_ptr_reg;
    logic        lk_phase_reg;
    logic [7:0]  lk_hi_reg;
    pmrc_write_t lk_wr_pay_reg;
    logic        lk_wr_tgl_reg;
    logic        lk_rd_tgl_reg;
    logic        lk_rd_idx_reg;
    logic        lk_rd_busy_reg;
    logic        lk_rd_again_reg;
    logic [1:0]  lk_wr_ack_sync;
    logic        lk_wr_ack_seen;
    logic [1:0]  lk_rd_ack_sync;
    logic        lk_rd_ack_seen;
    logic        lk_wr_done;
    logic        lk_rd_done;

    // core to link result word, held until next request
    logic [15:0] rd_data_reg;
    logic        rd_ack_tgl_reg;
    logic        wr_ack_tgl_reg;

    assign lk_wr_done = lk_wr_ack_sync[1] ^ lk_wr_ack_seen;
    assign lk_rd_done = lk_rd_ack_sync[1] ^ lk_rd_ack_seen;

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lk_wr_ack_sync <= 2'b00;
            lk_wr_ack_seen <= 1'b0;
            lk_rd_ack_sync <= 2'b00;
            lk_rd_ack_seen <= 1'b0;
        end else begin
            lk_wr_ack_sync <= {lk_wr_ack_sync[0], wr_ack_tgl_reg};
            lk_wr_ack_seen <= lk_wr_ack_sync[1];
            lk_rd_ack_sync <= {lk_rd_ack_sync[0], rd_ack_tgl_reg};
            lk_rd_ack_seen <= lk_rd_ack_sync[1];
        end
    end

    // pointer and paired write bytes
    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lk_ptr_reg    <= PTR_CONFIG;
            lk_phase_reg  <= 1'b0;
            lk_hi_reg     <= 8'h00;
            lk_wr_pay_reg <= '0;
            lk_wr_tgl_reg <= 1'b0;
            o_lk_wr_busy  <= 1'b0;
        end else begin
            if (i_lk_ptr_we) begin
                lk_ptr_reg   <= i_lk_byte[2:0];
                lk_phase_reg <= 1'b0;
            end else if (i_lk_wr_stb && !o_lk_wr_busy) begin
                if (!lk_phase_reg) begin
                    lk_hi_reg    <= i_lk_byte;
                    lk_phase_reg <= 1'b1;
                end else begin
                    lk_wr_pay_reg <= '{ptr: lk_ptr_reg, data: {lk_hi_reg, i_lk_byte}};
                    lk_wr_tgl_reg <= ~lk_wr_tgl_reg;
                    lk_phase_reg  <= 1'b0;
                end
            end
            if (i_lk_wr_stb && !o_lk_wr_busy && lk_phase_reg && !i_lk_ptr_we) begin
                o_lk_wr_busy <= 1'b1;
            end else if (lk_wr_done) begin
                o_lk_wr_busy <= 1'b0;
            end
        end
    end

    // read fetch and byte delivery
    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lk_rd_tgl_reg   <= 1'b0;
            lk_rd_idx_reg   <= 1'b0;
            lk_rd_busy_reg  <= 1'b0;
            lk_rd_again_reg <= 1'b0;
            o_lk_rd_valid   <= 1'b0;
            o_lk_rd_byte    <= 8'h00;
        end else if (i_lk_ptr_we) begin
            o_lk_rd_valid   <= 1'b0;
            lk_rd_busy_reg  <= 1'b1;
            lk_rd_again_reg <= lk_rd_busy_reg && !lk_rd_done;
            if (!lk_rd_busy_reg || lk_rd_done) begin
                lk_rd_tgl_reg <= ~lk_rd_tgl_reg;
            end
        end else if (lk_rd_done && lk_rd_again_reg) begin
            lk_rd_tgl_reg   <= ~lk_rd_tgl_reg;
            lk_rd_again_reg <= 1'b0;
        end else if (lk_rd_done) begin
            o_lk_rd_byte   <= rd_data_reg[15:8];
            o_lk_rd_valid  <= 1'b1;
            lk_rd_idx_reg  <= 1'b0;
            lk_rd_busy_reg <= 1'b0;
        end else if (i_lk_rd_stb && o_lk_rd_valid) begin
            if (!lk_rd_idx_reg) begin
                o_lk_rd_byte  <= rd_data_reg[7:0];
                lk_rd_idx_reg <= 1'b1;
            end else begin
                o_lk_rd_valid  <= 1'b0;
                lk_rd_tgl_reg  <= ~lk_rd_tgl_reg;
                lk_rd_busy_reg <= 1'b1;
            end
        end
    end

    // ---------------- core domain ----------------
    logic [1:0]     wr_sync;
    logic           wr_seen;
    logic [1:0]     rd_sync;
    logic           rd_seen;
    logic           wr_ev;
    logic           rd_ev;
    pmrc_wr_state_t wr_state_reg;
    pmrc_write_t    wr_pend_reg;
    logic [7:0]     wr_cnt_reg;
    logic           soft_rst;
    logic [15:0]    config_reg;
    logic [15:0]    calib_reg;
    logic [15:0]    shunt_reg;
    logic [15:0]    bus_reg;
    logic [15:0]    current_reg;
    logic [15:0]    power_reg;
    logic [15:0]    shunt_lim;
    logic [15:0]    shunt_mag;
    logic [15:0]    shunt_sat;
    logic signed [32:0] cur_prod;
    logic [15:0]    cur_next;
    logic [28:0]    pwr_prod;
    logic [15:0]    pwr_next;

    assign wr_ev    = wr_sync[1] ^ wr_seen;
    assign rd_ev    = rd_sync[1] ^ rd_seen;
    assign soft_rst = (wr_state_reg == WR_APPLY) && (wr_pend_reg.ptr == PTR_CONFIG)
                      && wr_pend_reg.data[15];

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_sync <= 2'b00;
            wr_seen <= 1'b0;
            rd_sync <= 2'b00;
            rd_seen <= 1'b0;
        end else begin
            wr_sync <= {wr_sync[0], lk_wr_tgl_reg};
            wr_seen <= wr_sync[1];
            rd_sync <= {rd_sync[0], lk_rd_tgl_reg};
            rd_seen <= rd_sync[1];
        end
    end

    // write settle delay before contents change
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_state_reg   <= WR_IDLE;
            wr_pend_reg    <= '0;
            wr_cnt_reg     <= 8'h00;
            wr_ack_tgl_reg <= 1'b0;
        end else begin
            case (wr_state_reg)
                WR_IDLE: begin
                    if (wr_ev) begin
                        wr_pend_reg  <= lk_wr_pay_reg;
                        wr_cnt_reg   <= WR_SETTLE_LD;
                        wr_state_reg <= WR_SETTLE;
                    end
                end
                WR_SETTLE: begin
                    if (wr_cnt_reg == 8'h00) begin
                        wr_state_reg <= WR_APPLY;
                    end else begin
                        wr_cnt_reg <= wr_cnt_reg - 8'h01;
                    end
                end
                WR_APPLY: begin
                    wr_ack_tgl_reg <= ~wr_ack_tgl_reg;
                    wr_state_reg   <= WR_IDLE;
                end
                default: wr_state_reg <= WR_IDLE;
            endcase
        end
    end

    // writable registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            config_reg <= CONFIG_RESET;
            calib_reg  <= CALIB_RESET;
        end else if (soft_rst) begin
            config_reg <= CONFIG_RESET;
            calib_reg  <= CALIB_RESET;
        end else if (wr_state_reg == WR_APPLY) begin
            if (wr_pend_reg.ptr == PTR_CONFIG) begin
                config_reg <= wr_pend_reg.data & CONFIG_WMASK;
            end else if (wr_pend_reg.ptr == PTR_CALIB) begin
                calib_reg <= wr_pend_reg.data;
            end
        end
    end

    // settings to the converter, fields kept as written except bit 14, held at zero, and bit 15, which soft-resets to the defaults
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_config <= pmrc_config_t'(CONFIG_RESET);
        end else begin
            o_config <= pmrc_config_t'(config_reg);
        end
    end

    // shunt result clamped to the gain range
    always_comb begin
        shunt_lim = SHUNT_BASE << {config_reg[12], config_reg[11]};
        shunt_mag = abs16(i_shunt_raw);
        if (shunt_mag > shunt_lim) begin
            shunt_sat = i_shunt_raw[15] ? 16'(~shunt_lim + 16'h0001) : shunt_lim;
        end else begin
            shunt_sat = i_shunt_raw;
        end
    end

    // measurement results
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shunt_reg <= RESULT_RESET;
            bus_reg   <= RESULT_RESET;
        end else if (soft_rst) begin
            shunt_reg <= RESULT_RESET;
            bus_reg   <= RESULT_RESET;
        end else begin
            if (i_shunt_valid) begin
                shunt_reg <= shunt_sat;
            end
            if (i_bus_valid) begin
                bus_reg <= {i_bus_raw, 3'b000};
            end
        end
    end

    // current and power arithmetic
    always_comb begin
        cur_prod = $signed({{17{shunt_reg[15]}}, shunt_reg}) * $signed({17'h0_0000, calib_reg});
        cur_next = 16'(cur_prod / CURRENT_DIV);
        pwr_prod = 29'(abs16(current_reg)) * 29'(bus_reg[15:BUS_SHIFT]);
        pwr_next = 16'(pwr_prod / POWER_DIV);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            current_reg <= RESULT_RESET;
            power_reg   <= RESULT_RESET;
        end else if (soft_rst || calib_reg == CALIB_RESET) begin
            current_reg <= RESULT_RESET;
            power_reg   <= RESULT_RESET;
        end else begin
            current_reg <= cur_next;
            power_reg   <= pwr_next;
        end
    end

    // read answer to the link
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_data_reg    <= 16'h0000;
            rd_ack_tgl_reg <= 1'b0;
        end else if (rd_ev) begin
            rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
            case (lk_ptr_reg)
                PTR_CONFIG:  rd_data_reg <= config_reg;
                PTR_SHUNT:   rd_data_reg <= shunt_reg;
                PTR_BUS:     rd_data_reg <= bus_reg;
                PTR_POWER:   rd_data_reg <= power_reg;
                PTR_CURRENT: rd_data_reg <= current_reg;
                PTR_CALIB:   rd_data_reg <= calib_reg;
                default:     rd_data_reg <= 16'h0000;
            endcase
        end
    end

    // ---------------- checks ----------------
    sequence s_write_arrives;
        (wr_state_reg == WR_IDLE) && wr_ev;
    endsequence

    sequence s_settle_done;
        (wr_state_reg == WR_SETTLE)[*1] ##WR_SETTLE_CYC (wr_state_reg == WR_APPLY);
    endsequence

    AST_WRITE_SETTLES: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write_arrives |=> s_settle_done)
        else $error("write did not apply after settle time");

    AST_SOFT_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        soft_rst |=> (config_reg == CONFIG_RESET) && (calib_reg == CALIB_RESET)
                     && !config_reg[15])
        else $error("soft reset did not restore defaults");

    AST_BIT14_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !config_reg[14])
        else $error("configuration bit 14 not zero");

    AST_ZERO_CAL: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ($past(calib_reg) == CALIB_RESET) |-> (current_reg == 16'h0000)
                                              && (power_reg == 16'h0000))
        else $error("results nonzero with zero calibration");

    AST_CURRENT_CALC: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (calib_reg != CALIB_RESET && !soft_rst)
            |=> current_reg == 16'(($signed($past(shunt_reg)) * $signed({1'b0, $past(calib_reg)}))
                                   / 4095))
        else $error("current result wrong");

    AST_POWER_CALC: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (calib_reg != CALIB_RESET && !soft_rst)
            |=> power_reg == 16'((29'(abs16($past(current_reg)))
                                 * 29'($past(bus_reg) >> 3)) / 5000))
        else $error("power result wrong");

    AST_BUS_ALIGN: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_bus_valid && !soft_rst) |=> (bus_reg[2:0] == 3'b000)
                                       && (bus_reg[15:3] == $past(i_bus_raw)))
        else $error("bus result misaligned");

    AST_SHUNT_SIGN: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_shunt_valid && !soft_rst && config_reg[12:11] == 2'b00)
            |=> (shunt_reg[15:12] == {4{shunt_reg[15]}}))
        else $error("shunt upper bits do not repeat sign");

    AST_CONFIG_OUT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ##1 o_config == pmrc_config_t'($past(config_reg)))
        else $error("converter settings do not follow configuration");

    AST_BYTE_ORDER: assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        (i_lk_rd_stb && o_lk_rd_valid && !lk_rd_idx_reg && !i_lk_ptr_we && !lk_rd_done)
            |=> o_lk_rd_byte == rd_data_reg[7:0])
        else $error("low byte not delivered second");

endmodule : pmrc_top
`default_nettype wire

/* File: verif/pmrc_host_model.sv */
// module: host-side link controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmrc_host_model (
    // link requests
    output var   logic       o_link_clk,
    output var   logic       o_ptr_we,
    output var   logic       o_wr_stb,
    output var   logic       o_rd_stb,
    output var   logic [7:0] o_byte,
    // link answers
    input  wire  logic [7:0] i_rd_byte,
    input  wire  logic       i_rd_valid,
    input  wire  logic       i_wr_busy
);
    logic run;
    int   hangs;

    // link clock stands still, low, whenever run is clear
    initial begin
        o_link_clk = 1'b0;
        forever begin
            #7.5;
            if (run || o_link_clk) begin
                o_link_clk = ~o_link_clk;
            end
        end
    end

    initial begin
        run = 1'b1;
        hangs = 0;
        o_ptr_we = 1'b0;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_byte = 8'h00;
    end

    task automatic spin(input int n);
        run = 1'b1;
        repeat (n) @(posedge o_link_clk);
        run = 1'b0;
    endtask : spin

    // one strobe with its byte, then byte inverted once released
    task automatic xfer(input logic [2:0] kind, input logic [7:0] b);
        @(posedge o_link_clk);
        #1;
        {o_ptr_we, o_wr_stb, o_rd_stb} = kind;
        o_byte = b;
        @(posedge o_link_clk);
        #1;
        {o_ptr_we, o_wr_stb, o_rd_stb} = 3'h0;
        o_byte = ~b;
    endtask : xfer

    task automatic wait_sig(input logic on_valid, input logic lvl);
        int n;
        n = 0;
        while (((on_valid ? i_rd_valid : i_wr_busy) !== lvl) && n < 600) begin
            @(posedge o_link_clk);
            #1;
            n++;
        end
        if (n >= 600) begin
            hangs++;
        end
    endtask : wait_sig

    task automatic write_reg(input logic [2:0] ptr, input logic [15:0] d);
        run = 1'b1;
        xfer(3'b100, {5'h00, ptr});
        xfer(3'b010, d[15:8]);
        xfer(3'b010, d[7:0]);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        run = 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [2:0] ptr, output logic [15:0] d);
        run = 1'b1;
        xfer(3'b100, {5'h00, ptr});
        wait_sig(1'b1, 1'b1);
        d[15:8] = i_rd_byte;
        xfer(3'b001, 8'hA5);
        @(posedge o_link_clk);
        #1;
        d[7:0] = i_rd_byte;
        xfer(3'b001, 8'h5A);
        wait_sig(1'b1, 1'b0);
        run = 1'b0;
    endtask : read_reg
endmodule : pmrc_host_model
`default_nettype wire

/* File: verif/power_monitor_register_calc_test.sv */
// module: self-checking bench for the power monitor register block
`timescale 1ns/1ps
`default_nettype none
module power_monitor_register_calc_test
    import pmrc_pkg::*;
;
    typedef struct packed {
        logic [15:0] sh;
        logic [12:0] bu;
        logic [15:0] cal;
        logic [15:0] cur;
        logic [15:0] pw;
    } pmrc_row_t;

    localparam pmrc_row_t ROWS [4] = '{
        '{16'h07D0, 13'h0BB3, 16'h5000, 16'h2712, 16'h1767},
        '{16'hF830, 13'h0BB3, 16'h5000, 16'hD8EE, 16'h1767},
        '{16'h07D0, 13'h0064, 16'h0000, 16'h0000, 16'h0000},
        '{16'h7D00, 13'h1FFF, 16'h1000, 16'h7D07, 16'hCCD1}
    };

    logic                 ref_clk;
    logic                 reset_n;
    logic                 shunt_valid;
    logic [15:0]          shunt_raw;
    logic                 bus_valid;
    logic [BUS_CNT_W-1:0] bus_raw;
    wire  logic           link_clk;
    wire  logic           ptr_we;
    wire  logic           wr_stb;
    wire  logic           rd_stb;
    wire  logic [7:0]     lk_byte;
    wire  logic [7:0]     rd_byte;
    wire  logic           rd_valid;
    wire  logic           wr_busy;
    pmrc_config_t         config_out;
    int                   err_count;
    int                   n_checks;
    logic [15:0]          cfg;

    pmrc_top pmrc_top_inst (
        .i_ref_clk     (ref_clk),
        .i_reset_n     (reset_n),
        .i_link_clk    (link_clk),
        .i_lk_ptr_we   (ptr_we),
        .i_lk_wr_stb   (wr_stb),
        .i_lk_rd_stb   (rd_stb),
        .i_lk_byte     (lk_byte),
        .o_lk_rd_byte  (rd_byte),
        .o_lk_rd_valid (rd_valid),
        .o_lk_wr_busy  (wr_busy),
        .i_shunt_valid (shunt_valid),
        .i_shunt_raw   (shunt_raw),
        .i_bus_valid   (bus_valid),
        .i_bus_raw     (bus_raw),
        .o_config      (config_out)
    );

    pmrc_host_model pmrc_host_model_inst (
        .o_link_clk (link_clk),
        .o_ptr_we   (ptr_we),
        .o_wr_stb   (wr_stb),
        .o_rd_stb   (rd_stb),
        .o_byte     (lk_byte),
        .i_rd_byte  (rd_byte),
        .i_rd_valid (rd_valid),
        .i_wr_busy  (wr_busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic read_check(input logic [2:0] ptr, input logic [15:0] exp);
        logic [15:0] d;
        pmrc_host_model_inst.read_reg(ptr, d);
        check(d, exp);
    endtask : read_check

    task automatic sample(input logic [15:0] sh, input logic [12:0] bu);
        @(posedge ref_clk);
        #1;
        shunt_raw = sh;
        bus_raw = bu;
        shunt_valid = 1'b1;
        bus_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        shunt_valid = 1'b0;
        bus_valid = 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : sample

    task automatic complete_run;
        err_count += pmrc_host_model_inst.hangs;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        #2_000_000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        reset_n = 1'b0;
        shunt_valid = 1'b0;
        bus_valid = 1'b0;
        shunt_raw = 16'h0000;
        bus_raw = '0;
        repeat (8) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        read_check(PTR_CURRENT, 16'h0000);
        // arithmetic rows
        for (int i = 0; i < 4; i++) begin
            pmrc_host_model_inst.write_reg(PTR_CALIB, ROWS[i].cal);
            sample(ROWS[i].sh, ROWS[i].bu);
            read_check(PTR_CALIB, ROWS[i].cal);
            read_check(PTR_SHUNT, ROWS[i].sh);
            read_check(PTR_BUS, {ROWS[i].bu, 3'h0});
            read_check(PTR_CURRENT, ROWS[i].cur);
            read_check(PTR_POWER, ROWS[i].pw);
        end
        $display("test rows done");
        // every field code, bit 14 written high
        for (int k = 0; k < 16; k++) begin
            cfg = {1'b0, 1'b1, k[0], k[1:0], k[3:0], ~k[3:0], k[2:0]};
            pmrc_host_model_inst.write_reg(PTR_CONFIG, cfg);
            read_check(PTR_CONFIG, cfg & 16'hBFFF);
            check(config_out, cfg & 16'hBFFF);
        end
        $display("test config fields done");
        // negative reading at each gain, overrange at all but the highest
        for (int g = 0; g < 4; g++) begin
            pmrc_host_model_inst.write_reg(PTR_CONFIG, {3'b001, g[1:0], 11'h19F});
            sample(16'h8300, 13'h0000);
            read_check(PTR_SHUNT, 16'(-(4000 << g)));
        end
        $display("test shunt gain done");
        pmrc_host_model_inst.write_reg(PTR_SHUNT, 16'h1234);
        read_check(PTR_SHUNT, 16'h8300);
        pmrc_host_model_inst.write_reg(3'h6, 16'hFFFF);
        read_check(3'h6, 16'h0000);
        $display("test read-only done");
        // soft reset
        pmrc_host_model_inst.write_reg(PTR_CALIB, 16'h5000);
        sample(16'h07D0, 13'h0BB3);
        pmrc_host_model_inst.write_reg(PTR_CONFIG, 16'h8000);
        read_check(PTR_CONFIG, 16'h399F);
        read_check(PTR_CALIB, 16'h0000);
        read_check(PTR_CURRENT, 16'h0000);
        read_check(PTR_POWER, 16'h0000);
        check(config_out, 16'h399F);
        $display("test soft reset done");
        // hardware reset in mid-run
        pmrc_host_model_inst.write_reg(PTR_CONFIG, 16'h0000);
        @(posedge ref_clk);
        #1;
        reset_n = 1'b0;
        pmrc_host_model_inst.spin(4);
        repeat (3) @(posedge ref_clk);
        #1;
        check(config_out, 16'h399F);
        reset_n = 1'b1;
        pmrc_host_model_inst.spin(4);
        read_check(PTR_CONFIG, 16'h399F);
        $display("test hard reset done");
        complete_run();
    end
endmodule : power_monitor_register_calc_test
`default_nettype wire
